//--- cst_pkg.sv
`default_nettype none
package cst_pkg;
    // ---------------------------------------------------------------
    // connection state values
    // ---------------------------------------------------------------
    localparam logic [7:0] ST_NONEXISTENT = 8'h00;
    localparam logic [7:0] ST_CONFIGURING = 8'h01;
    localparam logic [7:0] ST_ID_PENDING = 8'h02;
    localparam logic [7:0] ST_ESTABLISHED = 8'h03;
    localparam logic [7:0] ST_TIMED_OUT = 8'h04;
    // ---------------------------------------------------------------
    // connection type and identifiers
    // ---------------------------------------------------------------
    localparam logic [7:0] TYPE_EXPLICIT = 8'h00;
    localparam logic [7:0] TYPE_IO = 8'h01;
    localparam logic [15:0] ID_DEFAULT = 16'hFFFF;
    localparam logic [15:0] ID_MAX = 16'h07F0;
    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATE = 4'h1;
    localparam logic [3:0] REG_TYPE = 4'h2;
    localparam logic [3:0] REG_TX_ID = 4'h3;
    localparam logic [3:0] REG_RX_ID = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    // ctrl bit positions (write 1 to act)
    localparam int CTRL_CREATE = 0;
    localparam int CTRL_APPLY = 1;
    localparam int CTRL_DELETE = 2;
    localparam int CTRL_DYNAMIC = 3;
    localparam int CTRL_CONFIGURED = 4;

    typedef enum logic [2:0] {
        CST_NONE, CST_CONFIG, CST_IDWAIT, CST_ESTAB, CST_TIMEOUT
    } cst_state_type;

    function automatic logic cst_id_legal(input logic [15:0] id);
        return id <= ID_MAX;
    endfunction
endpackage
`default_nettype wire

//--- cst_match_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cst_match_if;
    logic frame_valid;
    logic [10:0] frame_id;
    logic [15:0] rx_id;
    logic active;
    logic accept;
    modport owner (output frame_valid, output frame_id, output rx_id, output active,
                   input accept);
    modport matcher (input frame_valid, input frame_id, input rx_id, input active,
                     output accept);
endinterface
`default_nettype wire

//--- cst_match.sv
`timescale 1ns/10ps
`default_nettype none
module cst_match (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // frame compare
    cst_match_if.matcher m
);
    typedef struct packed {
        logic accept;
    } cst_match_state_type;

    cst_match_state_type q, next_q;

    // ---------------------------------------------------------------
    // receive identifier compare
    // ---------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.accept = m.frame_valid && m.active && cst_pkg::cst_id_legal(m.rx_id)
            && ({5'h00, m.frame_id} == m.rx_id);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign m.accept = q.accept;

    accept_match_a: assert property (@(posedge mclk) disable iff (!resetn)
        m.accept |-> $past(m.frame_valid) && ($past({5'h00, m.frame_id}) == $past(m.rx_id)))
        else $error("frame accepted with mismatched identifier");
endmodule
`default_nettype wire

//--- cst_tracker.sv
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module cst_tracker (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // node events
    input wire logic ids_available,
    input wire logic watchdog_expired,
    input wire logic explicit_link_lost,
    // CAN frame side
    input wire logic tx_request,
    input wire logic rx_frame_valid,
    input wire logic [10:0] rx_frame_id,
    output logic tx_frame_valid,
    output logic [10:0] tx_frame_identifier,
    output logic rx_frame_accept,
    // connection status
    output logic [7:0] conn_state,
    output logic timers_start,
    output logic resources_released
);
    typedef struct packed {
        cst_pkg::cst_state_type st;
        logic configured;
        logic dynamic;
        logic [7:0] conn_type;
        logic [15:0] tx_frame_id_attr;
        logic [15:0] rx_frame_id_attr;
        logic [15:0] rdata;
        logic tx_valid;
        logic [10:0] tx_id;
        logic timers_start;
        logic released;
        logic [7:0] state_out;
    } cst_regs_type;

    cst_regs_type q, next_q;
    cst_match_if mif ();

    function automatic logic [7:0] cst_encode(input cst_pkg::cst_state_type s);
        case (s)
            cst_pkg::CST_NONE: return cst_pkg::ST_NONEXISTENT;
            cst_pkg::CST_CONFIG: return cst_pkg::ST_CONFIGURING;
            cst_pkg::CST_IDWAIT: return cst_pkg::ST_ID_PENDING;
            cst_pkg::CST_ESTAB: return cst_pkg::ST_ESTABLISHED;
            cst_pkg::CST_TIMEOUT: return cst_pkg::ST_TIMED_OUT;
            default: return cst_pkg::ST_NONEXISTENT;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // state and attributes
    // ---------------------------------------------------------------
    always_comb begin
        logic wr_ctrl;
        logic ids_ok;
        logic apply;
        wr_ctrl = reg_wr && (reg_addr == cst_pkg::REG_CTRL);
        apply = wr_ctrl && reg_wdata[cst_pkg::CTRL_APPLY];
        ids_ok = ids_available && cst_pkg::cst_id_legal(q.tx_frame_id_attr)
            && cst_pkg::cst_id_legal(q.rx_frame_id_attr);
        next_q = q;
        next_q.timers_start = 1'b0;
        next_q.released = 1'b0;
        next_q.rdata = 16'h0000;
        if (wr_ctrl && reg_wdata[cst_pkg::CTRL_CONFIGURED]) begin
            next_q.configured = 1'b1;
        end
        if (reg_wr && q.st == cst_pkg::CST_CONFIG) begin
            case (reg_addr)
                cst_pkg::REG_TYPE: begin
                    next_q.conn_type = reg_wdata[7:0];
                end
                cst_pkg::REG_TX_ID: begin
                    next_q.tx_frame_id_attr = reg_wdata;
                end
                cst_pkg::REG_RX_ID: begin
                    next_q.rx_frame_id_attr = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        if (reg_wr && q.st == cst_pkg::CST_IDWAIT) begin
            if (reg_addr == cst_pkg::REG_TX_ID) begin
                next_q.tx_frame_id_attr = reg_wdata;
            end
            if (reg_addr == cst_pkg::REG_RX_ID) begin
                next_q.rx_frame_id_attr = reg_wdata;
            end
        end
        case (q.st)
            cst_pkg::CST_NONE: begin
                if (wr_ctrl && reg_wdata[cst_pkg::CTRL_CREATE]) begin
                    next_q.st = cst_pkg::CST_CONFIG;
                    next_q.configured = reg_wdata[cst_pkg::CTRL_CONFIGURED];
                    next_q.dynamic = reg_wdata[cst_pkg::CTRL_DYNAMIC];
                    next_q.conn_type = cst_pkg::TYPE_IO;
                    next_q.tx_frame_id_attr = cst_pkg::ID_DEFAULT;
                    next_q.rx_frame_id_attr = cst_pkg::ID_DEFAULT;
                end
            end
            cst_pkg::CST_CONFIG: begin
                if (apply && (q.configured || reg_wdata[cst_pkg::CTRL_CONFIGURED])) begin
                    if (ids_ok) begin
                        next_q.st = cst_pkg::CST_ESTAB;
                        next_q.timers_start = 1'b1;
                    end else begin
                        next_q.st = cst_pkg::CST_IDWAIT;
                    end
                end
            end
            cst_pkg::CST_IDWAIT: begin
                if (ids_ok) begin
                    next_q.st = cst_pkg::CST_ESTAB;
                    next_q.timers_start = 1'b1;
                end
            end
            cst_pkg::CST_ESTAB: begin
                if (watchdog_expired) begin
                    next_q.st = cst_pkg::CST_TIMEOUT;
                end
            end
            cst_pkg::CST_TIMEOUT: begin
            end
            default: begin
                next_q.st = cst_pkg::CST_NONE;
            end
        endcase
        if (q.dynamic && explicit_link_lost && (q.st == cst_pkg::CST_CONFIG
                || q.st == cst_pkg::CST_IDWAIT)) begin
            next_q.st = cst_pkg::CST_NONE;
            next_q.released = 1'b1;
            next_q.dynamic = 1'b0;
            next_q.configured = 1'b0;
            next_q.timers_start = 1'b0;
            next_q.tx_frame_id_attr = cst_pkg::ID_DEFAULT;
            next_q.rx_frame_id_attr = cst_pkg::ID_DEFAULT;
        end else if (wr_ctrl && reg_wdata[cst_pkg::CTRL_DELETE]
                && q.st != cst_pkg::CST_NONE) begin
            next_q.st = cst_pkg::CST_NONE;
            next_q.released = 1'b1;
            next_q.dynamic = 1'b0;
            next_q.configured = 1'b0;
            next_q.timers_start = 1'b0;
        end
        next_q.state_out = cst_encode(next_q.st);
        // ---------------------------------------------------------------
        // transmit path
        // ---------------------------------------------------------------
        next_q.tx_valid = tx_request && q.st == cst_pkg::CST_ESTAB
            && cst_pkg::cst_id_legal(q.tx_frame_id_attr);
        next_q.tx_id = next_q.tx_valid ? q.tx_frame_id_attr[10:0] : 11'h000;
        // ---------------------------------------------------------------
        // register read
        // ---------------------------------------------------------------
        if (reg_rd) begin
            case (reg_addr)
                cst_pkg::REG_STATE: next_q.rdata = {8'h00, q.state_out};
                cst_pkg::REG_TYPE: next_q.rdata = {8'h00, q.conn_type};
                cst_pkg::REG_TX_ID: next_q.rdata = q.tx_frame_id_attr;
                cst_pkg::REG_RX_ID: next_q.rdata = q.rx_frame_id_attr;
                cst_pkg::REG_STATUS: next_q.rdata = {14'h0000, q.dynamic, q.configured};
                default: next_q.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q.st <= cst_pkg::CST_NONE;
            q.configured <= 1'b0;
            q.dynamic <= 1'b0;
            q.conn_type <= cst_pkg::TYPE_IO;
            q.tx_frame_id_attr <= cst_pkg::ID_DEFAULT;
            q.rx_frame_id_attr <= cst_pkg::ID_DEFAULT;
            q.rdata <= 16'h0000;
            q.tx_valid <= 1'b0;
            q.tx_id <= 11'h000;
            q.timers_start <= 1'b0;
            q.released <= 1'b0;
            q.state_out <= cst_pkg::ST_NONEXISTENT;
        end else begin
            q <= next_q;
        end
    end

    // ---------------------------------------------------------------
    // receive match
    // ---------------------------------------------------------------
    assign mif.frame_valid = rx_frame_valid;
    assign mif.frame_id = rx_frame_id;
    assign mif.rx_id = q.rx_frame_id_attr;
    assign mif.active = (q.st == cst_pkg::CST_ESTAB);

    cst_match u_match (
        .mclk(mclk),
        .resetn(resetn),
        .m(mif.matcher)
    );

    assign reg_rdata = q.rdata;
    assign tx_frame_valid = q.tx_valid;
    assign tx_frame_identifier = q.tx_id;
    assign rx_frame_accept = mif.accept;
    assign conn_state = q.state_out;
    assign timers_start = q.timers_start;
    assign resources_released = q.released;

    // ---------------------------------------------------------------
    // check helpers
    // ---------------------------------------------------------------
    logic ctrl_wr;
    logic link_drop;
    logic del_req;
    assign ctrl_wr = reg_wr && (reg_addr == cst_pkg::REG_CTRL);
    assign link_drop = q.dynamic && explicit_link_lost
        && (q.st == cst_pkg::CST_CONFIG || q.st == cst_pkg::CST_IDWAIT);
    assign del_req = ctrl_wr && reg_wdata[cst_pkg::CTRL_DELETE] && q.st != cst_pkg::CST_NONE;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    state_legal_a: assert property (@(posedge mclk) disable iff (!resetn)
        conn_state <= cst_pkg::ST_TIMED_OUT) else $error("reserved state value");
    state_known_a: assert property (@(posedge mclk) disable iff (!resetn)
        q.st inside {cst_pkg::CST_NONE, cst_pkg::CST_CONFIG, cst_pkg::CST_IDWAIT,
        cst_pkg::CST_ESTAB, cst_pkg::CST_TIMEOUT}) else $error("internal state outside set");
    delete_free_a: assert property (@(posedge mclk) disable iff (!resetn)
        (del_req && !link_drop) |=> resources_released
            && conn_state == cst_pkg::ST_NONEXISTENT) else $error("delete did not free");
    create_config_a: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == cst_pkg::CST_NONE && reg_wr && reg_addr == cst_pkg::REG_CTRL
         && reg_wdata[cst_pkg::CTRL_CREATE] && !reg_wdata[cst_pkg::CTRL_DELETE])
        |=> conn_state == cst_pkg::ST_CONFIGURING) else $error("create missed");
    config_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == cst_pkg::CST_CONFIG && !link_drop && !del_req
         && !(ctrl_wr && reg_wdata[cst_pkg::CTRL_APPLY]))
        |=> conn_state == cst_pkg::ST_CONFIGURING) else $error("configuring left early");
    idwait_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
        (conn_state == cst_pkg::ST_CONFIGURING ##1 conn_state == cst_pkg::ST_ID_PENDING)
        |-> $past(!ids_available) || $past(q.tx_frame_id_attr) > cst_pkg::ID_MAX
            || $past(q.rx_frame_id_attr) > cst_pkg::ID_MAX)
        else $error("id wait without missing identifiers");
    estab_cause_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(conn_state == cst_pkg::ST_ESTABLISHED) |-> $past(q.configured || reg_wr))
        else $error("established without configuration");
    apply_unconfig_a: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == cst_pkg::CST_CONFIG && !q.configured && ctrl_wr
         && !reg_wdata[cst_pkg::CTRL_CONFIGURED] && !link_drop && !del_req)
        |=> conn_state == cst_pkg::ST_CONFIGURING) else $error("apply before configure");
    timeout_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == cst_pkg::CST_ESTAB && watchdog_expired && !reg_wr)
        |=> conn_state == cst_pkg::ST_TIMED_OUT) else $error("timeout missed");
    timeout_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == cst_pkg::CST_TIMEOUT && !del_req) |=> conn_state == cst_pkg::ST_TIMED_OUT)
        else $error("timed out left without delete");
    link_release_a: assert property (@(posedge mclk) disable iff (!resetn)
        (q.dynamic && explicit_link_lost && q.st inside {cst_pkg::CST_CONFIG,
         cst_pkg::CST_IDWAIT}) |=> resources_released && conn_state == cst_pkg::ST_NONEXISTENT)
        else $error("dynamic connection not released");
    timers_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(conn_state == cst_pkg::ST_ESTABLISHED) == timers_start)
        else $error("timers not started on establish");
    create_default_a: assert property (@(posedge mclk) disable iff (!resetn)
        (q.st == cst_pkg::CST_NONE && ctrl_wr && reg_wdata[cst_pkg::CTRL_CREATE])
        |=> q.tx_frame_id_attr == cst_pkg::ID_DEFAULT
            && q.rx_frame_id_attr == cst_pkg::ID_DEFAULT
            && q.conn_type == cst_pkg::TYPE_IO) else $error("create defaults wrong");
    tx_ident_a: assert property (@(posedge mclk) disable iff (!resetn)
        tx_frame_valid |-> tx_frame_identifier == $past(q.tx_frame_id_attr[10:0])
            && $past(q.st == cst_pkg::CST_ESTAB)) else $error("tx identifier wrong");
    accept_active_a: assert property (@(posedge mclk) disable iff (!resetn)
        rx_frame_accept |-> $past(q.st == cst_pkg::CST_ESTAB))
        else $error("frame accepted while not established");

    estab_cover_c: cover property (@(posedge mclk) disable iff (!resetn)
        $rose(conn_state == cst_pkg::ST_ESTABLISHED));
    idwait_cover_c: cover property (@(posedge mclk) disable iff (!resetn)
        conn_state == cst_pkg::ST_ID_PENDING ##[1:20] conn_state == cst_pkg::ST_ESTABLISHED);
    timeout_cover_c: cover property (@(posedge mclk) disable iff (!resetn)
        $rose(conn_state == cst_pkg::ST_TIMED_OUT));
    release_cover_c: cover property (@(posedge mclk) disable iff (!resetn)
        resources_released);
    delete_cover_c: cover property (@(posedge mclk) disable iff (!resetn)
        del_req && !link_drop);
endmodule
`default_nettype wire

//--- cst_far_node.sv
`timescale 1ns/10ps
`default_nettype none
module cst_far_node (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // frames from the node
    input wire logic tx_frame_valid,
    input wire logic [10:0] tx_frame_identifier,
    // frames to the node
    output var logic rx_frame_valid,
    output var logic [10:0] rx_frame_id
);
    int tx_count;
    logic [10:0] last_tx;

    initial begin
        rx_frame_valid = 1'b0;
        rx_frame_id = 11'h000;
    end

    // ---------------------------------------------------------------
    // send one frame after gap+1 clock edges; idle bus shows inverse id
    // ---------------------------------------------------------------
    task automatic send(input logic [10:0] id, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        rx_frame_valid <= 1'b1;
        rx_frame_id <= id;
        @(posedge mclk);
        rx_frame_valid <= 1'b0;
        rx_frame_id <= ~id;
    endtask

    // ---------------------------------------------------------------
    // record frames the node puts on the bus
    // ---------------------------------------------------------------
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tx_count <= 0;
            last_tx <= 11'h000;
        end else if (tx_frame_valid) begin
            tx_count <= tx_count + 1;
            last_tx <= tx_frame_identifier;
        end
    end
endmodule
`default_nettype wire

//--- connection_state_tracker_tb.sv
`timescale 1ns/10ps
`default_nettype none
module connection_state_tracker_tb;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic ids_available = 1'b1;
    logic watchdog_expired = 1'b0;
    logic explicit_link_lost = 1'b0;
    logic tx_request = 1'b0;
    logic rx_frame_valid;
    logic [10:0] rx_frame_id;
    logic tx_frame_valid;
    logic [10:0] tx_frame_identifier;
    logic rx_frame_accept;
    logic [7:0] conn_state;
    logic timers_start;
    logic resources_released;
    logic [15:0] rv;
    int fails = 0;
    int checks = 0;

    always #10 mclk = ~mclk;

    cst_tracker dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ids_available(ids_available),
        .watchdog_expired(watchdog_expired), .explicit_link_lost(explicit_link_lost),
        .tx_request(tx_request), .rx_frame_valid(rx_frame_valid), .rx_frame_id(rx_frame_id),
        .tx_frame_valid(tx_frame_valid), .tx_frame_identifier(tx_frame_identifier),
        .rx_frame_accept(rx_frame_accept), .conn_state(conn_state),
        .timers_start(timers_start), .resources_released(resources_released));

    cst_far_node far (.mclk(mclk), .resetn(resetn), .tx_frame_valid(tx_frame_valid),
        .tx_frame_identifier(tx_frame_identifier), .rx_frame_valid(rx_frame_valid),
        .rx_frame_id(rx_frame_id));

    // ---------------------------------------------------------------
    // bus, event and compare helpers
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // 0 watchdog expiry, 1 explicit link loss, 2 transmit request
    task automatic ev(input int k);
        @(posedge mclk);
        watchdog_expired <= (k == 0);
        explicit_link_lost <= (k == 1);
        tx_request <= (k == 2);
        @(posedge mclk);
        watchdog_expired <= 1'b0;
        explicit_link_lost <= 1'b0;
        tx_request <= 1'b0;
        #1;
    endtask

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_NONEXISTENT});
        rd(cst_pkg::REG_STATE, rv);
        check("state reg", rv, 16'h0000);
        rd(4'hF, rv);
        check("unmapped", rv, 16'h0000);
        $display("reset test done");
    endtask

    task automatic t_open();
        wr(cst_pkg::REG_CTRL, 16'h0011);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_CONFIGURING});
        rd(cst_pkg::REG_TYPE, rv);
        check("type", rv, {8'h00, cst_pkg::TYPE_IO});
        rd(cst_pkg::REG_RX_ID, rv);
        check("rx id", rv, cst_pkg::ID_DEFAULT);
        wr(cst_pkg::REG_TX_ID, 16'h0123);
        wr(cst_pkg::REG_RX_ID, cst_pkg::ID_MAX);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_CONFIGURING});
        wr(cst_pkg::REG_CTRL, 16'h0002);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_ESTABLISHED});
        check("timers", {15'h0000, timers_start}, 16'h0001);
        $display("open test done");
    endtask

    task automatic t_frames();
        far.send(cst_pkg::ID_MAX[10:0], 0);
        #1;
        check("accept", {15'h0000, rx_frame_accept}, 16'h0001);
        far.send(11'h7EF, 2);
        #1;
        check("accept", {15'h0000, rx_frame_accept}, 16'h0000);
        ev(2);
        check("tx valid", {15'h0000, tx_frame_valid}, 16'h0001);
        check("tx id", {5'h00, tx_frame_identifier}, 16'h0123);
        @(posedge mclk);
        #1;
        check("far count", far.tx_count[15:0], 16'h0001);
        check("far id", {5'h00, far.last_tx}, 16'h0123);
        wr(cst_pkg::REG_TYPE, 16'h0000);
        rd(cst_pkg::REG_TYPE, rv);
        check("type", rv, {8'h00, cst_pkg::TYPE_IO});
        $display("frame test done");
    endtask

    task automatic t_timeout();
        ev(0);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_TIMED_OUT});
        far.send(cst_pkg::ID_MAX[10:0], 0);
        #1;
        check("accept", {15'h0000, rx_frame_accept}, 16'h0000);
        ev(2);
        check("tx valid", {15'h0000, tx_frame_valid}, 16'h0000);
        wr(cst_pkg::REG_CTRL, 16'h0004);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_NONEXISTENT});
        $display("timeout test done");
    endtask

    task automatic t_idwait();
        ids_available <= 1'b0;
        wr(cst_pkg::REG_CTRL, 16'h0019);
        wr(cst_pkg::REG_TX_ID, 16'h0010);
        wr(cst_pkg::REG_RX_ID, 16'h0020);
        wr(cst_pkg::REG_CTRL, 16'h0002);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_ID_PENDING});
        rd(cst_pkg::REG_TX_ID, rv);
        check("tx id", rv, 16'h0010);
        rd(cst_pkg::REG_STATUS, rv);
        check("status", rv, 16'h0003);
        ids_available <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            if (conn_state === cst_pkg::ST_ESTABLISHED) break;
        end
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_ESTABLISHED});
        check("timers", {15'h0000, timers_start}, 16'h0001);
        ev(1);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_ESTABLISHED});
        check("released", {15'h0000, resources_released}, 16'h0000);
        $display("id wait test done");
    endtask

    task automatic t_linklost();
        wr(cst_pkg::REG_CTRL, 16'h0004);
        check("released", {15'h0000, resources_released}, 16'h0001);
        ids_available <= 1'b0;
        wr(cst_pkg::REG_CTRL, 16'h0009);
        wr(cst_pkg::REG_CTRL, 16'h0002);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_CONFIGURING});
        wr(cst_pkg::REG_CTRL, 16'h0012);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_ID_PENDING});
        ev(1);
        check("state", {8'h00, conn_state}, {8'h00, cst_pkg::ST_NONEXISTENT});
        check("released", {15'h0000, resources_released}, 16'h0001);
        rd(cst_pkg::REG_RX_ID, rv);
        check("rx id", rv, cst_pkg::ID_DEFAULT);
        $display("link loss test done");
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_open();
        t_frames();
        t_timeout();
        t_idwait();
        t_linklost();
        results();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        results();
    end
endmodule
`default_nettype wire
